// [hw/iodb_ports.sv]
`timescale 1ns/100ps
`include "iodb_consts.svh"
module iodb_ports
   import iodb_pkg::*;
#(
   parameter int          SHORT_CYC = `IODB_DB_SHORT_CYC,
   parameter int          LONG_CYC  = `IODB_DB_LONG_CYC,
   parameter bit [2:0]    KEEP_FIT  = 3'h7
) (
   input  wire logic       clock_i,
   input  wire logic       srst_i,
   input  wire logic [3:0] sense_in_i,
   input  wire logic [3:0] key_in_i,
   input  wire logic [3:0] ser_in_i,
   input  wire logic       sense_pull_en_i,
   input  wire logic       key_pull_en_i,
   input  wire logic       ser_pull_en_i,
   input  wire logic [3:0] sense_det_en_i,
   input  wire logic [3:0] sense_db_en_i,
   input  wire logic       key_det_en_i,
   input  wire logic       key_db_en_i,
   input  wire logic       db_long_i,
   input  wire logic       key_wr_i,
   input  wire logic [3:0] key_wdata_i,
   input  wire logic [3:0] key_dir_i,
   input  wire logic       ser_wr_i,
   input  wire logic [3:0] ser_wdata_i,
   input  wire logic [3:0] ser_dir_i,
   input  wire logic       ser_od_i,
   input  wire iodb_ser_t  ser_mode_i,
   input  wire logic       ser_sdo_i,
   input  wire logic       ser_sck_i,
   input  wire logic       ser_sck_oe_i,
   input  wire logic       ser_sdo_oe_i,
   input  wire logic       flag_clr_i,
   output iodb_pin_t       key_pin_o,
   output iodb_pin_t       ser_pin_o,
   output iodb_pad_t       sense_pad_o,
   output iodb_pad_t       key_pad_o,
   output iodb_pad_t       ser_pad_o,
   output logic [3:0]      sense_val_o,
   output logic [3:0]      key_val_o,
   output logic            ser_sdi_o,
   output logic [7:0]      event_flag_o,
   output logic            wake_o,
   output logic            wake_irq_o
);
   // ----------------------------------------
   // parameter checks
   // ----------------------------------------
   // a zero count or a long interval below the short one breaks the compare
   if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC) begin
      $error("iodb_ports: bad debounce counts");
   end
   localparam int CW = $clog2(LONG_CYC + 1);

   // ----------------------------------------
   // debounce filter: 8 bits, shared counter length
   // ----------------------------------------
   logic [7:0]    raw, db_en, det_en;
   logic [7:0]    stab_reg, stab_next, samp_reg, samp_next;
   logic [7:0]    flag_reg, flag_next;
   logic [CW-1:0] cnt_reg [8];
   logic [CW-1:0] cnt_next [8];
   logic [CW-1:0] limit;

   assign raw    = {key_in_i, sense_in_i};
   assign db_en  = {{4{key_db_en_i}}, sense_db_en_i};
   assign det_en = {{4{key_det_en_i}}, sense_det_en_i};
   // one selectable interval for all bits keeps one compare per bit
   assign limit  = db_long_i ? CW'(LONG_CYC) : CW'(SHORT_CYC);

   always_comb begin
      stab_next = stab_reg;
      samp_next = raw;
      flag_next = flag_reg & ~{8{flag_clr_i}};
      for (int i = 0; i < 8; i++) begin
         cnt_next[i] = cnt_reg[i];
         if (!db_en[i]) begin
            cnt_next[i]  = '0;
            stab_next[i] = samp_reg[i];
         end else if (samp_reg[i] == stab_reg[i]) begin
            // a bounce back restarts the count, so noise never settles early
            cnt_next[i] = '0;
         end else if (cnt_reg[i] >= limit - CW'(1)) begin
            cnt_next[i]  = '0;
            stab_next[i] = samp_reg[i];
         end else begin
            cnt_next[i] = cnt_reg[i] + CW'(1);
         end
         // set beats clear
         if (det_en[i] && stab_next[i] != stab_reg[i])
            flag_next[i] = 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         stab_reg <= '0;
         samp_reg <= '0;
         flag_reg <= '0;
         for (int i = 0; i < 8; i++)
            cnt_reg[i] <= '0;
      end else begin
         stab_reg <= stab_next;
         samp_reg <= samp_next;
         flag_reg <= flag_next;
         for (int i = 0; i < 8; i++)
            cnt_reg[i] <= cnt_next[i];
      end
   end

   // ----------------------------------------
   // output latches, direction, pin drive
   // ----------------------------------------
   logic [3:0] klat_reg, klat_next, kdir_reg, kdir_next;
   logic [3:0] slat_reg, slat_next, sdir_reg, sdir_next;
   logic [2:0] pull_reg, pull_next;
   logic [2:0] keep_reg;
   logic       wk_reg, wk_next, wirq_reg, wirq_next;
   logic       sdi_reg, sdi_next;
   iodb_pin_t  kpin_next, spin_next;
   iodb_pin_t  kpin_reg, spin_reg;
   logic [3:0] sdrv, soe;

   always_comb begin
      klat_next = key_wr_i ? key_wdata_i : klat_reg;
      slat_next = ser_wr_i ? ser_wdata_i : slat_reg;
      kdir_next = key_dir_i;
      sdir_next = ser_dir_i;
      // pulls follow software once reset has gone
      pull_next = {ser_pull_en_i, key_pull_en_i, sense_pull_en_i};
      sdrv = slat_reg;
      soe  = sdir_reg;
      sdi_next = ser_in_i[0];
      case (ser_mode_i)
         IODB_SER_3WIRE: begin
            sdrv[1] = ser_sdo_i;
            soe[1]  = 1'b1;
            soe[0]  = 1'b0;
            sdrv[2] = ser_sck_i;
            soe[2]  = ser_sck_oe_i;
         end
         IODB_SER_2WIRE: begin
            // data shares the output pin both ways
            sdrv[1] = ser_sdo_i;
            soe[1]  = ser_sdo_oe_i;
            soe[0]  = 1'b0;
            sdrv[2] = ser_sck_i;
            soe[2]  = ser_sck_oe_i;
            sdi_next = ser_in_i[1];
         end
         default: ;
      endcase
      // open drain: only drive low
      if (ser_od_i)
         soe = soe & ~sdrv;
      kpin_next.in  = key_in_i;
      kpin_next.out = klat_reg;
      kpin_next.oe  = kdir_reg;
      spin_next.in  = ser_in_i;
      spin_next.out = ser_od_i ? 4'h0 : sdrv;
      spin_next.oe  = soe;
      // wake only while the shifter and the pin driver leave pin 4 free
      wk_next   = ser_mode_i == IODB_SER_OFF && !sdir_reg[3]
                  && !ser_in_i[3];
      // one pulse per wake event; a held low pin does not re-raise it
      wirq_next = wk_next && !wk_reg;
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         klat_reg <= `IODB_LATCH_RST;
         slat_reg <= `IODB_LATCH_RST;
         kdir_reg <= '0;
         sdir_reg <= '0;
         pull_reg <= 3'h7;
         keep_reg <= 3'h0;
         // pins show the preset latches while the drivers are off
         kpin_reg <= '{in: 4'h0, out: `IODB_LATCH_RST, oe: 4'h0};
         spin_reg <= '{in: 4'h0, out: `IODB_LATCH_RST, oe: 4'h0};
         wk_reg   <= 1'b0;
         wirq_reg <= 1'b0;
         sdi_reg  <= 1'b0;
      end else begin
         klat_reg <= klat_next;
         slat_reg <= slat_next;
         kdir_reg <= kdir_next;
         sdir_reg <= sdir_next;
         pull_reg <= pull_next;
         keep_reg <= KEEP_FIT;
         kpin_reg <= kpin_next;
         spin_reg <= spin_next;
         wk_reg   <= wk_next;
         wirq_reg <= wirq_next;
         sdi_reg  <= sdi_next;
      end
   end

   // ----------------------------------------
   // keepers and port outputs
   // ----------------------------------------
   // keeper holds the last sampled level; only where fitted
   logic [2:0][3:0] kv_reg;
   always_ff @(posedge clock_i) begin
      kv_reg <= {ser_in_i, key_in_i, sense_in_i};
   end

   assign sense_pad_o = '{pull_reg[0], {4{keep_reg[0]}},
                          kv_reg[0]};
   assign key_pad_o   = '{pull_reg[1], {4{keep_reg[1]}},
                          kv_reg[1]};
   assign ser_pad_o   = '{pull_reg[2], {4{keep_reg[2]}},
                          kv_reg[2]};
   assign key_pin_o    = kpin_reg;
   assign ser_pin_o    = spin_reg;
   assign sense_val_o  = stab_reg[3:0];
   assign key_val_o    = stab_reg[7:4];
   assign ser_sdi_o    = sdi_reg;
   assign event_flag_o = flag_reg;
   assign wake_o       = wk_reg;
   assign wake_irq_o   = wirq_reg;
endmodule

// [hw/iodb_consts.svh]
`ifndef IODB_CONSTS_SVH
`define IODB_CONSTS_SVH
`define IODB_CLK_HZ        100000000
`define IODB_DB_SHORT_US   1950
`define IODB_DB_LONG_US    7800
`define IODB_DB_SHORT_CYC  ((`IODB_CLK_HZ / 1000) * `IODB_DB_SHORT_US / 1000)
`define IODB_DB_LONG_CYC   ((`IODB_CLK_HZ / 1000) * `IODB_DB_LONG_US / 1000)
`define IODB_LATCH_RST     4'hf
`endif

// [hw/iodb_pkg.sv]
package iodb_pkg;
   typedef struct packed {
      logic [3:0] in;
      logic [3:0] out;
      logic [3:0] oe;
   } iodb_pin_t;
   typedef struct packed {
      logic       pull_en;
      logic [3:0] keep_en;
      logic [3:0] keep_val;
   } iodb_pad_t;
   typedef enum logic [1:0] {
      IODB_SER_OFF, IODB_SER_3WIRE, IODB_SER_2WIRE
   } iodb_ser_t;
endpackage

// [sim/iodb_ports_assertions.sv]
`timescale 1ns/100ps
module iodb_ports_chk
   import iodb_pkg::*;
(
   input wire logic       clock_i,
   input wire logic       srst_i,
   input wire logic       sense_pull_en_i,
   input wire logic       ser_od_i,
   input wire logic [3:0] key_dir_i,
   input wire logic [3:0] sense_det_en_i,
   input wire iodb_pin_t  key_pin_o,
   input wire iodb_pin_t  ser_pin_o,
   input wire iodb_pad_t  sense_pad_o,
   input wire iodb_pad_t  key_pad_o,
   input wire iodb_pad_t  ser_pad_o,
   input wire logic [3:0] sense_val_o,
   input wire logic [7:0] event_flag_o,
   input wire logic       wake_irq_o
);
   // ---
   // port checks
   // ---
   logic [3:0] val_q, det_q;
   always_ff @(posedge clock_i) begin
      val_q <= sense_val_o;
      det_q <= sense_det_en_i;
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (srst_i);
   // held three cycles so the pin register has caught up
   sequence s_dir_out; (key_dir_i == 4'hf && !srst_i) [*3]; endsequence
   sequence s_od_on; (ser_od_i && !srst_i) [*3]; endsequence
   property p_pull_rst; disable iff (1'b0) srst_i |=>
      sense_pad_o.pull_en && key_pad_o.pull_en && ser_pad_o.pull_en;
   endproperty
   property p_rst_state; disable iff (1'b0) srst_i |=>
      key_pin_o.oe == 4'h0 && ser_pin_o.oe == 4'h0 &&
      key_pin_o.out == 4'hf && key_pad_o.keep_en == 4'h0;
   endproperty
   property p_keep_on;
      $fell(srst_i) |=> key_pad_o.keep_en == 4'hf && ser_pad_o.keep_en == 4'hf;
   endproperty
   property p_pull_follow;
      !$past(srst_i) |-> sense_pad_o.pull_en == $past(sense_pull_en_i);
   endproperty
   property p_key_pp; s_dir_out |-> key_pin_o.oe == 4'hf; endproperty
   property p_ser_od; s_od_on |-> ser_pin_o.out == 4'h0; endproperty
   property p_flag_set;
      det_q[0] && sense_val_o[0] != val_q[0] |-> event_flag_o[0];
   endproperty
   property p_wake_pulse; wake_irq_o |=> !wake_irq_o; endproperty
   a_pull_rst: assert property (p_pull_rst) else $error("pull off");
   a_rst_state: assert property (p_rst_state) else $error("rst pins");
   a_keep_on: assert property (p_keep_on) else $error("keeper idle");
   a_pull_follow: assert property (p_pull_follow) else $error("pull");
   a_key_pp: assert property (p_key_pp) else $error("key not driven");
   a_ser_od: assert property (p_ser_od) else $error("od high");
   a_flag_set: assert property (p_flag_set) else $error("no flag");
   a_wake_pulse: assert property (p_wake_pulse) else $error("irq");
endmodule
bind iodb_ports iodb_ports_chk i_chk (.*);

// [sim/iodb_switch_model.sv]
`timescale 1ns/100ps
module iodb_switch_model (
   input  wire logic       clock_i,
   input  wire logic [3:0] level_i,
   input  wire logic [3:0] bounce_i,
   output logic      [3:0] pin_o
);
   // ---
   // contacts chatter for bounce_i cycles after each level change
   // ---
   logic [3:0] left = 4'h0, last = 4'h0;
   initial pin_o = 4'h0;
   always @(posedge clock_i) begin
      if (level_i != last) left <= bounce_i;
      else if (left != 4'h0) left <= left - 4'h1;
      last <= level_i;
      pin_o <= (left != 4'h0) ? ~pin_o : level_i;
   end
endmodule

// [sim/input_io_ports_with_debounce_test.sv]
`timescale 1ns/100ps
`define CHK(n, e, s) begin \
   check_count++; \
   if ((s) !== (e)) begin \
      fails++; \
      $display("BAD %s exp %h got %h", n, e, s); \
   end \
end
module input_io_ports_with_debounce_test;
   import iodb_pkg::*;
   // ---
   // stimulus and checks
   // ---
   logic       clock_i = 0, srst_i = 1, db_long_i = 0, flag_clr_i = 0;
   logic       sense_pull_en_i = 0, key_pull_en_i = 0, ser_pull_en_i = 0;
   logic       key_det_en_i = 0, key_db_en_i = 0, key_wr_i = 0, ser_wr_i = 0;
   logic       ser_od_i = 0, ser_sdo_i = 0, ser_sck_i = 0, seen;
   logic       ser_sck_oe_i = 0, ser_sdo_oe_i = 0, wake_o, wake_irq_o;
   logic       ser_sdi_o;
   logic [3:0] sense_in_i, key_in_i, ser_in_i = 4'hf, sense_det_en_i = 0;
   logic [3:0] sense_db_en_i = 0, key_wdata_i = 0, key_dir_i = 0, kv;
   logic [3:0] ser_wdata_i = 0, ser_dir_i = 0, sense_val_o, key_val_o;
   logic [3:0] lvl = 4'h0, bnc = 4'h0, sv, ef;
   logic [7:0] event_flag_o;
   iodb_ser_t  ser_mode_i = IODB_SER_OFF;
   iodb_pin_t  key_pin_o, ser_pin_o;
   iodb_pad_t  sense_pad_o, key_pad_o, ser_pad_o;
   int         fails = 0, check_count = 0;
   iodb_ports #(.SHORT_CYC(4), .LONG_CYC(16)) i_iodb_ports (.*);
   iodb_switch_model i_sense_sw (.clock_i, .level_i(lvl), .bounce_i(bnc),
      .pin_o(sense_in_i));
   iodb_switch_model i_key_sw (.clock_i, .level_i(lvl), .bounce_i(bnc),
      .pin_o(key_in_i));
   always #5 clock_i = ~clock_i;
   // chatter reaches undebounced bits whenever the port level moves
   function automatic logic [3:0] efl(input logic [3:0] det, db, now, was);
      return det & ((~db & {4{now != was}}) | (now ^ was));
   endfunction
   function automatic logic [2:0] pulls();
      return {sense_pad_o.pull_en, key_pad_o.pull_en, ser_pad_o.pull_en};
   endfunction
   function automatic logic [11:0] keeps();
      return {sense_pad_o.keep_en, key_pad_o.keep_en, ser_pad_o.keep_en};
   endfunction
   task automatic step(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   task automatic wrap_up;
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #100000;
      fails++;
      wrap_up;
   end
   initial begin
      void'($urandom(66448));
      step(5);
      `CHK("rst_pull", 3'h7, pulls())
      `CHK("rst_keep", 12'h000, keeps())
      `CHK("rst_out", 4'hf, key_pin_o.out)
      `CHK("rst_oe", 8'h00, {key_pin_o.oe, ser_pin_o.oe})
      srst_i = 0;
      step(2);
      `CHK("pull", 3'h0, pulls())
      `CHK("keep", 12'hfff, keeps())
      `CHK("latch", 4'hf, key_pin_o.out)
      {sense_pull_en_i, key_pull_en_i, ser_pull_en_i} = 3'h7;
      step(2);
      `CHK("pull_on", 1'b1, key_pad_o.pull_en)
      for (int i = 0; i < 12; i++) begin
         sense_det_en_i = 4'($urandom);
         sense_db_en_i = 4'($urandom);
         db_long_i = i[0];
         key_det_en_i = i[1];
         key_db_en_i = 1;
         flag_clr_i = 1;
         step(1);
         flag_clr_i = 0;
         {sv, kv, bnc} = {sense_val_o, key_val_o, 4'hc};
         lvl = 4'($urandom);
         step(6);
         `CHK("hold", sv & sense_db_en_i, sense_val_o & sense_db_en_i)
         step(40);
         `CHK("val", lvl, sense_val_o)
         `CHK("kval", lvl, key_val_o)
         `CHK("pad_val", lvl, sense_pad_o.keep_val)
         ef = efl(sense_det_en_i, sense_db_en_i, lvl, sv);
         `CHK("flag", ef, event_flag_o[3:0])
         ef = efl({4{key_det_en_i}}, 4'hf, lvl, kv);
         `CHK("kflag", ef, event_flag_o[7:4])
      end
      {key_dir_i, key_wdata_i, key_wr_i} = {4'hf, 4'($urandom), 1'b1};
      {ser_dir_i, ser_od_i, ser_wdata_i, ser_wr_i} = {4'hf, 1'b1, 4'h5, 1'b1};
      step(1);
      {key_wr_i, ser_wr_i} = 2'h0;
      step(2);
      `CHK("kout", {key_wdata_i, 4'hf}, {key_pin_o.out, key_pin_o.oe})
      `CHK("od", 8'h0a, {ser_pin_o.out, ser_pin_o.oe})
      {ser_od_i, ser_sdo_i, ser_sdo_oe_i, ser_sck_oe_i} = 4'h7;
      ser_mode_i = IODB_SER_3WIRE;
      ser_in_i = 4'($urandom);
      step(3);
      `CHK("sdi", ser_in_i[0], ser_sdi_o)
      `CHK("sout", 2'h1, ser_pin_o.out[2:1])
      ser_mode_i = IODB_SER_2WIRE;
      ser_sdo_oe_i = 1'b0;
      ser_in_i = ~ser_in_i;
      step(3);
      `CHK("two_wire", ser_in_i[1], ser_sdi_o)
      `CHK("two_wire_oe", 1'b0, ser_pin_o.oe[1])
      ser_mode_i = IODB_SER_OFF;
      ser_dir_i = 4'h0;
      ser_in_i = 4'hf;
      seen = 1'b0;
      step(3);
      ser_in_i = 4'h7;
      for (int i = 0; i < 10; i++) begin
         step(1);
         seen |= wake_irq_o;
      end
      `CHK("wake", 2'h3, {seen, wake_o})
      wrap_up;
   end
endmodule
